// File: src/ssfe_front_end.sv
/*
  Serial flash SPI front end: decodes instructions from the serial pins,
  drives read data, gates writes and keeps the protection bits.
  Assumes the serial clock is slow against clk_sys (at least 8 cycles per
  period) and an array controller on clk_sys behind the op/rd/pg ports.
*/
// Contract
// - Deselected: ignore bus, output released
// - Select low enables shifting in and out
// - Input bits captured on rising clock
// - Output bits change on falling clock
// - Clock idle low or high both work
// - Only dual read drives serial_io
// - Pause starts now or after falling clock
// - Pause ends now or after falling clock
// - Paused: output released, clock and data ignored
// - Pause keeps instruction and buffered bytes
// - Write instructions refused during power-up delay
// - Latch clear at reset; writes need it
// - Completed write operation clears latch
// - write_guard_n with status_lock guards status
// - Range bits make array parts read-only
// - Power-down ignores all but release
// - Lock set and guard low refuse status write
// - Bottom bit picks protected array end
// - Instruction code first, MSB first
// - Write instructions need whole bytes
`timescale 1ns/1ps
`default_nettype none
module ssfe_front_end
  import ssfe_pkg::*;
#(
  parameter int PUW_CYC = ssfe_pkg::PUW_CYCLES,
  parameter int DEPTH = ssfe_pkg::FIFO_DEPTH
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // power-on reset
  input wire logic sclk, // serial clock pin
  input wire logic cs_n, // device_select_n pin
  input wire logic pause_n, // pause pin
  input wire logic write_guard_n, // hardware status guard
  input wire logic serial_io_in, // serial_io level
  output logic serial_io_out, // serial_io drive value
  output logic serial_io_oe, // serial_io driven
  output logic serial_out, // serial_out drive value
  output logic serial_out_oe, // serial_out driven
  output logic op_valid, // array operation pulse
  output logic [7:0] op_code, // operation code
  output logic [ssfe_pkg::ADDR_W-1:0] op_addr, // operation address
  output logic op_abort, // discard buffered page
  input wire logic op_done, // array finished operation
  input wire logic array_busy, // array operation running
  output logic rd_req, // read byte request
  output logic [ssfe_pkg::ADDR_W-1:0] rd_addr, // read address
  input wire logic [7:0] rd_data, // byte, same cycle as rd_req
  output logic [ssfe_pkg::FIFO_WIDTH-1:0] pg_data, // page byte
  output logic pg_valid, // page byte present
  input wire logic pg_ready, // array takes page byte
  output logic write_latch, // write enable latch
  output logic status_lock, // status lock bit
  output logic protect_from_bottom, // range from bottom
  output logic [2:0] protect_range, // protected range
  output logic power_down, // in power-down
  output logic overrun // page byte lost, sticky
);
  typedef struct packed {
    ssfe_phase_t phase;
    logic sclk_prev;
    logic cs_prev;
    logic sel;
    logic paused;
    logic [7:0] cmd;
    logic [7:0] sh_in;
    logic [2:0] bit_cnt;
    logic [1:0] byte_cnt;
    logic [ADDR_W-1:0] addr;
    logic [7:0] sh_out;
    logic load;
    logic drv;
    logic so;
    logic so_oe;
    logic io;
    logic io_oe;
    logic wl;
    logic lock;
    logic bottom;
    logic [2:0] range;
    logic pd;
    logic [19:0] puw;
    logic [7:0] sr_new;
    logic sr_got;
    logic op_valid;
    logic [7:0] op_code;
    logic [ADDR_W-1:0] op_addr;
    logic op_abort;
    logic rd_req;
    logic [ADDR_W-1:0] rd_addr;
    logic push;
    logic ovr;
  } ssfe_state_t;
  ssfe_state_t s, next_s;

  logic sclk_s, cs_s, pause_n_s, guard_n_s, io_s;
  logic rise, fall, dual, wen_ok, we_go, fifo_ready;
  logic [2:0] step, nbit;
  logic [7:0] byte_in;
  logic [ADDR_W-1:0] a;

  generate
    if (PUW_CYC < 1 || PUW_CYC >= (1 << 20)) begin : g_bad_puw
      $error("ssfe_front_end: PUW_CYC out of range");
    end
  endgenerate

  // Select and clock load low: a select held low through reset is no
  // fresh high-to-low edge, and a clock idling low gives no false edge after reset
  ssfe_sync #(.W(5)) u_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .async_in({sclk, cs_n, pause_n, write_guard_n, serial_io_in}),
    .rst_val(5'h06),
    .sync_out({sclk_s, cs_s, pause_n_s, guard_n_s, io_s})
  );

  ssfe_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(DEPTH)) u_fifo (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .in_valid(s.push),
    .in_ready(fifo_ready),
    .in_data(s.sh_in),
    .out_valid(pg_valid),
    .out_ready(pg_ready),
    .out_data(pg_data)
  );

  // Edges found by level change, so either idle level is fine
  assign rise = sclk_s && !s.sclk_prev;
  assign fall = !sclk_s && s.sclk_prev;
  assign dual = s.cmd == CMD_DUAL;
  assign step = (s.phase == PH_DOUT && dual) ? 3'h2 : 3'h1;
  assign nbit = s.bit_cnt + step;
  assign byte_in = {s.sh_in[6:0], io_s};
  assign wen_ok = s.wl && s.puw == '0;
  assign we_go = cs_s && s.sel && s.cmd == CMD_WEN && s.bit_cnt == '0
    && s.phase == PH_DONE && s.puw == '0;

  always_comb begin
    next_s = s;
    a = s.addr;
    next_s.sclk_prev = sclk_s;
    next_s.cs_prev = cs_s;
    next_s.op_valid = 1'h0;
    next_s.op_abort = 1'h0;
    next_s.rd_req = 1'h0;
    next_s.push = 1'h0;
    if (s.push && !fifo_ready)
      next_s.ovr = 1'h1;
    if (s.puw != '0)
      next_s.puw = s.puw - 1'h1;
    if (op_done)
      next_s.wl = 1'h0;
    if (s.load) begin
      next_s.load = 1'h0;
      next_s.sh_out = (s.cmd == CMD_RSR)
        ? ssfe_status(array_busy, s.wl, s.range, s.bottom, s.lock) : rd_data;
    end
    if (cs_s) begin
      // Instruction ends: execute writes only on a byte boundary
      if (s.sel && s.bit_cnt == '0 && s.phase != PH_IGNORE
          && s.phase != PH_CMD) begin
        next_s.op_code = s.cmd;
        next_s.op_addr = s.addr;
        case (s.cmd)
          CMD_WEN: begin
            if (s.phase == PH_DONE && s.puw == '0)
              next_s.wl = 1'h1;
          end
          CMD_WDIS: begin
            if (s.phase == PH_DONE)
              next_s.wl = 1'h0;
          end
          CMD_WSR: begin
            if (s.sr_got && wen_ok && !(s.lock && !guard_n_s)) begin
              next_s.range = s.sr_new[SR_RANGE +: 3];
              next_s.bottom = s.sr_new[SR_BOTTOM];
              next_s.lock = s.sr_new[SR_LOCK];
              next_s.op_valid = 1'h1;
            end
          end
          CMD_PROG, CMD_SECT, CMD_BLOCK: begin
            if (s.phase != PH_ADDR && wen_ok
                && !ssfe_protected(s.addr[BLK_LSB +: 6], s.range, s.bottom))
              next_s.op_valid = 1'h1;
            else
              next_s.op_abort = s.cmd == CMD_PROG;
          end
          CMD_CHIP: begin
            if (s.phase == PH_DONE && wen_ok && s.range == '0)
              next_s.op_valid = 1'h1;
          end
          CMD_PDOWN: begin
            if (s.phase == PH_DONE)
              next_s.pd = 1'h1;
          end
          CMD_WAKE: begin
            next_s.pd = 1'h0;
          end
          default: begin
          end
        endcase
      end else if (s.sel && s.cmd == CMD_PROG) begin
        next_s.op_abort = 1'h1;
      end
      // Also the way out of a pause cut short by deselection
      next_s.sel = 1'h0;
      next_s.paused = 1'h0;
      next_s.phase = PH_IDLE;
      next_s.bit_cnt = '0;
      next_s.byte_cnt = '0;
      next_s.drv = 1'h0;
      next_s.load = 1'h0;
      next_s.sr_got = 1'h0;
    end else if (s.cs_prev && !s.sel) begin
      // Only a seen high-to-low select starts an instruction
      next_s.sel = 1'h1;
      next_s.phase = PH_CMD;
      next_s.paused = 1'h0;
    end else if (s.sel) begin
      if (pause_n_s == s.paused && (!sclk_s || fall))
        next_s.paused = !pause_n_s;
      // While paused the shift, count, phase and address fields stand
      if (!s.paused && rise) begin
        next_s.sh_in = byte_in;
        next_s.bit_cnt = nbit;
        if (nbit == '0) begin
          case (s.phase)
            PH_CMD: begin
              next_s.cmd = byte_in;
              next_s.phase = PH_DONE;
              if ((s.pd && byte_in != CMD_WAKE)
                  || (array_busy && byte_in != CMD_RSR))
                next_s.phase = PH_IGNORE;
              else if (byte_in == CMD_RSR) begin
                next_s.phase = PH_DOUT;
                next_s.load = 1'h1;
              end else if (byte_in == CMD_WSR)
                next_s.phase = PH_DIN;
              else if (byte_in == CMD_READ || byte_in == CMD_FAST
                       || byte_in == CMD_DUAL || byte_in == CMD_PROG
                       || byte_in == CMD_SECT || byte_in == CMD_BLOCK)
                next_s.phase = PH_ADDR;
              else if (byte_in != CMD_WEN && byte_in != CMD_WDIS
                       && byte_in != CMD_CHIP && byte_in != CMD_PDOWN
                       && byte_in != CMD_WAKE)
                next_s.phase = PH_IGNORE;
            end
            PH_ADDR: begin
              a = {s.addr[ADDR_W-9:0], byte_in};
              next_s.addr = a;
              next_s.byte_cnt = s.byte_cnt + 1'h1;
              if (s.byte_cnt == 2'(ADDR_BYTES - 1)) begin
                if (s.cmd == CMD_READ) begin
                  next_s.phase = PH_DOUT;
                  next_s.rd_req = 1'h1;
                  next_s.load = 1'h1;
                  next_s.rd_addr = a;
                  next_s.addr = a + 1'h1;
                end else if (s.cmd == CMD_FAST || s.cmd == CMD_DUAL)
                  next_s.phase = PH_DUMMY;
                else if (s.cmd == CMD_PROG)
                  next_s.phase = PH_DIN;
                else
                  next_s.phase = PH_DONE;
              end
            end
            PH_DUMMY, PH_DOUT: begin
              next_s.phase = PH_DOUT;
              next_s.load = 1'h1;
              if (s.cmd != CMD_RSR) begin
                next_s.rd_req = 1'h1;
                next_s.rd_addr = s.addr;
                next_s.addr = s.addr + 1'h1;
              end
            end
            PH_DIN: begin
              next_s.push = s.cmd == CMD_PROG;
              if (s.cmd == CMD_WSR && !s.sr_got) begin
                next_s.sr_new = byte_in;
                next_s.sr_got = 1'h1;
              end
            end
            default: begin
            end
          endcase
        end
      end
      if (!s.paused && fall && s.phase == PH_DOUT && !s.load) begin
        next_s.so = s.sh_out[7];
        next_s.io = s.sh_out[6];
        next_s.sh_out = dual ? {s.sh_out[5:0], 2'h0} : {s.sh_out[6:0], 1'h0};
        next_s.drv = 1'h1;
      end
    end
    next_s.so_oe = next_s.drv && next_s.sel && !next_s.paused;
    next_s.io_oe = next_s.so_oe && dual;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
      s.phase <= PH_IDLE;
      s.sclk_prev <= 1'h0;
      s.wl <= 1'h0;
      s.lock <= LOCK_RST;
      s.bottom <= BOTTOM_RST;
      s.range <= RANGE_RST;
      s.puw <= 20'(PUW_CYC);
    end else begin
      s <= next_s;
    end
  end

  assign serial_io_out = s.io;
  assign serial_io_oe = s.io_oe;
  assign serial_out = s.so;
  assign serial_out_oe = s.so_oe;
  assign op_valid = s.op_valid;
  assign op_code = s.op_code;
  assign op_addr = s.op_addr;
  assign op_abort = s.op_abort;
  assign rd_req = s.rd_req;
  assign rd_addr = s.rd_addr;
  assign write_latch = s.wl;
  assign status_lock = s.lock;
  assign protect_from_bottom = s.bottom;
  assign protect_range = s.range;
  assign power_down = s.pd;
  assign overrun = s.ovr;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  sequence q_pause_asked;
    s.sel && !cs_s && !s.paused && !pause_n_s;
  endsequence
  sequence q_resume_asked;
    s.sel && !cs_s && s.paused && pause_n_s;
  endsequence

  a_desel_quiet: assert property (cs_s |=> !serial_out_oe && !serial_io_oe)
    else $error("output driven while deselected");
  a_pause_quiet: assert property (s.paused |-> !serial_out_oe ##1 !s.rd_req)
    else $error("activity while paused");
  a_dual_only: assert property (serial_io_oe |-> s.cmd == CMD_DUAL && serial_out_oe)
    else $error("serial_io driven outside dual read");
  a_out_on_fall: assert property ($changed(serial_out) && serial_out_oe
    |-> $past(fall))
    else $error("serial_out changed off a falling edge");
  a_capture_rise: assert property (rise && s.sel && !s.paused && !cs_s
    |=> s.sh_in[0] == $past(io_s))
    else $error("input bit not captured on rising edge");
  a_pause_start: assert property (q_pause_asked ##0 !sclk_s |=> s.paused)
    else $error("pause not entered with clock low");
  a_pause_end: assert property (q_resume_asked ##0 (!sclk_s || fall)
    |=> !s.paused)
    else $error("pause not left");
  a_puw_block: assert property ($rose(s.wl) |-> $past(s.puw) == '0)
    else $error("latch set during power-up delay");
  a_latch_clear: assert property (op_done && !we_go |=> !s.wl)
    else $error("latch not cleared by completion");
  a_status_guard: assert property ($changed({s.lock, s.bottom, s.range})
    |-> $past(guard_n_s || !s.lock) && $past(s.wl))
    else $error("status changed while guarded");
  a_desel_reset: assert property (cs_s && s.sel
    |=> s.phase == PH_IDLE && s.bit_cnt == '0 ##1 !s.sel)
    else $error("counters not reset on deselect");
endmodule // ssfe_front_end
`default_nettype wire

// File: common/ssfe_pkg.sv
/*
  Shared constants, codes and helpers of the serial flash SPI front end.
  Assumes a 20 MHz system clock that oversamples the serial clock.
*/
`default_nettype none
package ssfe_pkg;
  localparam int CLK_PERIOD_NS = 50;
  localparam int PUW_TIME_NS = 10000;
  localparam int PUW_CYCLES = (PUW_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FIFO_WIDTH = 8;
  localparam int FIFO_DEPTH = 16;
  localparam int ADDR_W = 24;
  localparam int BLK_LSB = 16;
  localparam int ADDR_BYTES = 3;

  localparam logic [7:0] CMD_WSR = 8'h01;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_WDIS = 8'h04;
  localparam logic [7:0] CMD_RSR = 8'h05;
  localparam logic [7:0] CMD_WEN = 8'h06;
  localparam logic [7:0] CMD_FAST = 8'h0b;
  localparam logic [7:0] CMD_SECT = 8'h20;
  localparam logic [7:0] CMD_DUAL = 8'h3b;
  localparam logic [7:0] CMD_PDOWN = 8'hb9;
  localparam logic [7:0] CMD_CHIP = 8'hc7;
  localparam logic [7:0] CMD_BLOCK = 8'hd8;
  localparam logic [7:0] CMD_WAKE = 8'hab;

  localparam int SR_BUSY = 0;
  localparam int SR_WLATCH = 1;
  localparam int SR_RANGE = 2;
  localparam int SR_BOTTOM = 5;
  localparam int SR_LOCK = 7;
  localparam logic [2:0] RANGE_RST = 3'h0;
  localparam logic BOTTOM_RST = 1'h0;
  localparam logic LOCK_RST = 1'h0;

  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_CMD = 3'b001,
    PH_ADDR = 3'b010,
    PH_DUMMY = 3'b011,
    PH_DIN = 3'b100,
    PH_DOUT = 3'b101,
    PH_DONE = 3'b110,
    PH_IGNORE = 3'b111
  } ssfe_phase_t;

  // Range 1..6 guards 1,2,4..32 blocks; 7 guards all 64
  function automatic logic ssfe_protected(input logic [5:0] blk,
                                          input logic [2:0] range,
                                          input logic bottom);
    logic [6:0] cnt;
    // A plain shift would wrap to zero for range 7 in seven bits
    cnt = (range == 3'h7) ? 7'h40 : (7'h01 << range) >> 1;
    if (bottom)
      ssfe_protected = {1'h0, blk} < cnt;
    else
      ssfe_protected = {1'h0, blk} >= (7'h40 - cnt);
  endfunction

  function automatic logic [7:0] ssfe_status(input logic busy,
                                             input logic wl,
                                             input logic [2:0] range,
                                             input logic bottom,
                                             input logic lock);
    ssfe_status = '0;
    ssfe_status[SR_BUSY] = busy;
    ssfe_status[SR_WLATCH] = wl;
    ssfe_status[SR_RANGE +: 3] = range;
    ssfe_status[SR_BOTTOM] = bottom;
    ssfe_status[SR_LOCK] = lock;
  endfunction
endpackage
`default_nettype wire

// File: src/ssfe_sync.sv
/*
  Two-stage synchroniser for a group of independent level inputs.
  Assumes each bit is a slow level; no bus coherence is implied.
*/
`timescale 1ns/1ps
`default_nettype none
module ssfe_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic [W-1:0] async_in, // pins from other domains
  input wire logic [W-1:0] rst_val, // constant level during reset
  output logic [W-1:0] sync_out // second stage
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } ssfe_sync_t;
  ssfe_sync_t s, next_s;

  generate
    if (W < 1) begin : g_bad
      $error("ssfe_sync: W must be at least 1");
    end
  endgenerate

  always_comb begin
    next_s.meta = async_in;
    next_s.stable = s.meta;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s.meta <= rst_val;
      s.stable <= rst_val;
    end else begin
      s <= next_s;
    end
  end

  assign sync_out = s.stable;
endmodule // ssfe_sync
`default_nettype wire

// File: src/ssfe_fifo.sv
/*
  Page data FIFO with valid/ready on both sides.
  Assumes both sides run on clk_sys; depth is a power of two.
*/
`timescale 1ns/1ps
`default_nettype none
module ssfe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_sys, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic in_valid, // word offered
  output logic in_ready, // room for a word
  input wire logic [WIDTH-1:0] in_data, // word in
  output logic out_valid, // word available
  input wire logic out_ready, // drain side takes it
  output logic [WIDTH-1:0] out_data // oldest word
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } ssfe_fifo_t;
  ssfe_fifo_t s, next_s;
  logic do_wr, do_rd;

  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
      $error("ssfe_fifo: DEPTH must be a power of two >= 2");
    end
  endgenerate

  assign in_ready = s.cnt != DEPTH[AW:0];
  assign out_valid = s.cnt != '0;
  assign out_data = s.mem[s.rd];
  assign do_wr = in_valid && in_ready;
  assign do_rd = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (do_wr) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = s.wr + 1'h1;
    end
    if (do_rd)
      next_s.rd = s.rd + 1'h1;
    if (do_wr && !do_rd)
      next_s.cnt = s.cnt + 1'h1;
    else if (do_rd && !do_wr)
      next_s.cnt = s.cnt - 1'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s.cnt <= DEPTH[AW:0])
    else $error("fifo count beyond depth");
  a_fifo_count: assert property (@(posedge clk_sys) disable iff (sys_rst)
    do_wr && !do_rd |=> s.cnt == $past(s.cnt) + 1'h1)
    else $error("fifo count missed a write");
endmodule // ssfe_fifo
`default_nettype wire

// File: sim/ssfe_master.sv
/*
  SPI bus master model: frames on a 400 ns serial clock, with pause.
  Assumes the bench fills tx, sets pz, xb and dual, and reads rx and ioe.
*/
`timescale 1ns/1ps
`default_nettype none
module ssfe_master (
  output logic sclk, // serial clock
  output logic cs_n, // device select, active low
  output logic pause_n, // pause, active low
  output logic io_lvl, // serial_io wire level
  input wire logic io_out, // device serial_io value
  input wire logic io_oe, // device drives serial_io
  input wire logic so, // device serial_out value
  input wire logic so_oe // device drives serial_out
);
  logic m_oe, m_io, tgl, dual, ioe;
  logic [7:0] tx[$], rx[$];
  int pz, xb;
  // Released wires toggle, so a stale bit can never pass for data
  assign io_lvl = io_oe ? io_out : m_oe ? m_io : tgl;
  initial begin
    {sclk, cs_n, pause_n, m_oe, m_io, tgl, dual} = 7'h38;
    pz = -1;
    xb = 0;
  end
  always #100 tgl = ~tgl;
  task automatic cyc(input logic d, output logic [1:0] r);
    sclk = 0;
    m_io = d;
    #200 sclk = 1;
    #190 r = {so_oe ? so : tgl, io_lvl};
    ioe |= io_oe;
    #10;
  endtask
  // Entered and left at whatever clock level it meets, so both the
  // immediate and the wait-for-fall cases of a pause are exercised
  task automatic hold();
    pause_n = 0;
    repeat (3) begin
      #200 sclk = ~sclk;
      m_io = ~m_io;
    end
    #100 pause_n = 1;
    #100;
  endtask
  task automatic frame(input bit m3, input int nrx);
    logic [1:0] r;
    logic [7:0] b;
    int n;
    n = 0;
    ioe = 0;
    rx.delete();
    sclk = m3;
    #200 cs_n = 0;
    #200;
    foreach (tx[i]) for (int k = 7; k >= 0; k--) begin
      if (n++ == pz) hold();
      cyc(tx[i][k], r);
    end
    repeat (xb) cyc(1'b1, r);
    m_oe = !dual;
    repeat (nrx) begin
      for (int k = 0; k < (dual ? 4 : 8); k++) begin
        cyc(tgl, r);
        b = dual ? {b[5:0], r} : {b[6:0], r[1]};
      end
      rx.push_back(b);
    end
    if (!m3) sclk = 0;
    #200 cs_n = 1;
    m_oe = 1;
    pz = -1;
    xb = 0;
    dual = 0;
    #400;
  endtask
endmodule // ssfe_master
`default_nettype wire

// File: sim/ssfe_front_end_bench.sv
/*
  Self-checking bench of the serial flash front end.
  Assumes ssfe_master as bus master and a tiny array model kept here.
*/
`timescale 1ns/1ps
`default_nettype none
module ssfe_front_end_bench;
  import ssfe_pkg::*;
  localparam int PUW = 120;
  logic clk_sys, sys_rst, sclk, cs_n, pause_n, write_guard_n, io_lvl;
  logic serial_io_out, serial_io_oe, serial_out, serial_out_oe, op_valid;
  logic op_abort, op_done, array_busy, rd_req, pg_valid, pg_ready;
  logic write_latch, status_lock, protect_from_bottom, power_down, overrun;
  logic [7:0] op_code, rd_data, pg_data, v;
  logic [23:0] op_addr, rd_addr, pa, ua;
  logic [2:0] protect_range;
  logic [4:0] st;
  logic [7:0] pq[$];
  int mismatches, tests_run, nop, nab, seed;
  ssfe_front_end #(.PUW_CYC(PUW)) i_dut (.clk_sys, .sys_rst, .sclk, .cs_n,
    .pause_n, .write_guard_n, .serial_io_in(io_lvl), .serial_io_out,
    .serial_io_oe, .serial_out, .serial_out_oe, .op_valid, .op_code,
    .op_addr, .op_abort, .op_done, .array_busy, .rd_req, .rd_addr, .rd_data,
    .pg_data, .pg_valid, .pg_ready, .write_latch, .status_lock,
    .protect_from_bottom, .protect_range, .power_down, .overrun);
  ssfe_master i_m (.sclk, .cs_n, .pause_n, .io_lvl, .io_out(serial_io_out),
    .io_oe(serial_io_oe), .so(serial_out), .so_oe(serial_out_oe));
  function automatic logic [7:0] mem(input logic [23:0] a);
    return a[23:16] ^ a[15:8] ^ a[7:0] ^ 8'h5a;
  endfunction
  // Array read port: data stands in the same cycle as rd_req
  assign #1 rd_data = mem(rd_addr);
  initial begin
    clk_sys = 0;
    forever #25 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    nop += op_valid;
    nab += op_abort;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: saw %0h, want %0h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic cmd(input logic [7:0] c);
    i_m.tx = {c};
    i_m.frame(0, 0);
  endtask
  task automatic rd(input bit m3, input bit du, input logic [23:0] a);
    i_m.tx = {du ? CMD_DUAL : CMD_READ, a[23:16], a[15:8], a[7:0]};
    if (du) i_m.tx.push_back(8'h00);
    i_m.dual = du;
    i_m.frame(m3, 3);
    foreach (i_m.rx[i]) chk(i_m.rx[i], mem(a + 24'(i)));
    chk(i_m.ioe, du);
    chk(serial_out_oe, 0);
  endtask
  task automatic fin_op();
    tick(1);
    op_done = 1;
    tick(1);
    op_done = 0;
    tick(2);
  endtask
  task automatic wsr(input logic [7:0] w);
    bit ok;
    ok = !(st[4] && !write_guard_n);
    cmd(CMD_WEN);
    i_m.tx = {CMD_WSR, w};
    i_m.frame(0, 0);
    if (ok) st = {w[7], w[5], w[4:2]};
    chk({status_lock, protect_from_bottom, protect_range}, st);
    if (ok) fin_op();
    chk(write_latch, !ok);
  endtask
  task automatic pg(input logic [23:0] a, input int nd, input int xb);
    cmd(CMD_WEN);
    i_m.tx = {CMD_PROG, a[23:16], a[15:8], a[7:0]};
    repeat (nd) begin
      i_m.tx.push_back(8'($random(seed)));
      if (pq.size() < 16) pq.push_back(i_m.tx[$]);
    end
    i_m.xb = xb;
    i_m.frame(0, 0);
    tick(1);
  endtask
  task automatic test_done();
    $display("checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    seed = 32'hcef37171;
    {sys_rst, write_guard_n, op_done, array_busy, pg_ready} = 5'h18;
    st = 0;
    tick(2);
    sys_rst = 0;
    chk({write_latch, serial_out_oe, serial_io_oe, power_down}, 0);
    tick(8);
    cmd(CMD_WEN);
    chk(write_latch, 0);
    tick(PUW);
    cmd(CMD_WEN);
    chk(write_latch, 1);
    cmd(CMD_WDIS);
    i_m.pz = 4;
    cmd(CMD_WEN);
    chk(write_latch, 1);
    i_m.pz = 0;
    cmd(CMD_WDIS);
    chk(write_latch, 0);
    rd(0, 0, 24'($random(seed)));
    rd(1, 0, 24'hfffffe);
    rd(0, 1, 24'($random(seed)));
    cmd(CMD_PDOWN);
    cmd(CMD_WEN);
    chk({power_down, write_latch}, 2'h2);
    cmd(CMD_WAKE);
    chk(power_down, 0);
    v = 8'($random(seed));
    wsr({2'h2, v[0], 3'(v[2:1]) + 3'h1, 2'h0});
    tick(1);
    write_guard_n = 0;
    wsr(8'h00);
    i_m.tx = {CMD_RSR};
    i_m.frame(0, 2);
    chk(i_m.rx.size(), 2);
    foreach (i_m.rx[i]) chk(i_m.rx[i], {st[4], 1'h0, st[3:0], 2'h2});
    tick(1);
    write_guard_n = 1;
    pa = st[3] ? 24'h000000 : 24'h3f0000;
    ua = st[3] ? 24'h3f0000 : 24'h000000;
    {nop, nab} = 0;
    pg(pa, 1, 0);
    pg(ua, 1, 3);
    chk(nop, 0);
    chk(nab, 2);
    chk(pg_valid, 1);
    // The array drops what the aborted programs left in the buffer
    pg_ready = 1;
    tick(3);
    pg_ready = 0;
    chk(pg_valid, 0);
    pq.delete();
    pg(ua, 17, 0);
    chk({pg_valid, overrun}, 2'h3);
    chk(op_code, CMD_PROG);
    chk(op_addr, ua);
    // Random ready keeps the drain side stalling while bytes leave
    for (int i = 0; i < 600 && pq.size() > 0; i++) begin
      pg_ready = 1'($random(seed));
      @(negedge clk_sys);
      if (pg_valid && pg_ready) chk(pg_data, pq.pop_front());
      tick(1);
    end
    chk(pq.size(), 0);
    chk(pg_valid, 0);
    fin_op();
    chk(write_latch, 0);
    test_done();
  end
endmodule // ssfe_front_end_bench
`default_nettype wire
